// File: hw/cqr_pkg.sv
/*
  Constants, types and lookup functions for the CAN query and cyclic read handler.
  Assumes one 25 MHz clock and a CAN controller that moves whole frames on the same clock.
*/
package cqr_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MIN_INTERVAL_MS = 16'h0014;
  localparam int NUM_CYC = 7;
  localparam int NUM_STD_CYC = 5;

  localparam logic [10:0] QUERY_ID_OFS = 11'h001;
  localparam logic [10:0] RESP_ID_OFS = 11'h002;
  localparam logic [15:0] ERR_REG = 16'hFFFF;
  localparam logic [7:0] MARKER_FIRST = 8'hFF;
  localparam logic [7:0] ERR_ADDR = 8'h02;
  localparam logic [7:0] ERR_DATA = 8'h03;
  localparam logic [3:0] DLC_ERR = 4'h3;
  localparam logic [3:0] DLC_FULL = 4'h8;
  localparam logic [3:0] DLC_QUERY_MIN = 4'h2;
  localparam logic [3:0] SINGLE_HDR = 4'h2;
  localparam logic [3:0] SPLIT_HDR = 4'h3;
  localparam logic [7:0] SINGLE_MAX_REGS = 8'h03;
  localparam logic [2:0] STATUS_OBJ = 3'h0;

  // Register map of the control port
  localparam logic [7:0] ADDR_BASE_ID = 8'h00;
  localparam logic [7:0] ADDR_CYC_BASE_ID = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INTERVAL0 = 8'h10;
  localparam int CTRL_CYC_EN = 0;
  localparam int CTRL_BIDIR = 1;
  localparam int STS_BUSY = 0;
  localparam int STS_QPEND = 1;
  localparam int STS_CPEND = 8;
  localparam logic [10:0] BASE_ID_RESET = 11'h020;
  localparam logic [10:0] CYC_BASE_ID_RESET = 11'h100;

  // Registers with multi-register object definitions
  localparam logic [15:0] REG_STATUS = 16'd505;
  localparam logic [15:0] REG_USER_TEXT = 16'd171;
  localparam logic [7:0] LEN_STATUS = 8'd2;
  localparam logic [7:0] LEN_USER_TEXT = 8'd20;
  localparam logic [7:0] LEN_DEFAULT = 8'd1;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cqr_frame_type;

  typedef struct packed {
    logic remote;
    logic output_on_req;
    logic fast_regulator;
    logic voltage_current_power_regulation;
    logic any_alarm;
    logic master_slave_safety_alarm;
    logic overcurrent_event_alarm;
    logic overcurrent_protection_alarm;
    logic [4:0] access_interface;
    logic power_event_alarm;
    logic power_protection_alarm;
    logic overtemperature_alarm;
    logic voltage_event_alarm;
    logic overvoltage_alarm;
    logic power_fail_alarm;
    logic remote_standby;
    logic undercurrent_event;
    logic undervoltage_event;
    logic external_sensing;
    logic function_generator;
    logic master_unit;
    logic output_on;
    logic [1:0] regulation_mode;
    logic sink_side;
  } cqr_status_type;

  // Object size in registers, from the definition of the start register
  function automatic logic [7:0] obj_len(input logic [15:0] reg_num);
    if (reg_num == REG_STATUS) begin
      obj_len = LEN_STATUS;
    end else if (reg_num == REG_USER_TEXT) begin
      obj_len = LEN_USER_TEXT;
    end else begin
      obj_len = LEN_DEFAULT;
    end
  endfunction

  // Number of 16-bit words carried by each cyclic object
  function automatic logic [7:0] cyc_words(input logic [2:0] obj);
    case (obj)
      3'h0: cyc_words = 8'd2;
      3'h1: cyc_words = 8'd3;
      3'h2: cyc_words = 8'd4;
      3'h3: cyc_words = 8'd4;
      3'h4: cyc_words = 8'd2;
      3'h5: cyc_words = 8'd3;
      default: cyc_words = 8'd4;
    endcase
  endfunction

  // Source register of each word slot of a cyclic object
  function automatic logic [15:0] cyc_reg(input logic [2:0] obj, input logic [1:0] slot);
    logic [63:0] tbl;
    tbl = 64'h0;
    case (obj)
      3'h1: tbl = {16'd507, 16'd508, 16'd509, 16'd0};
      3'h2: tbl = {16'd500, 16'd501, 16'd502, 16'd503};
      3'h3: tbl = {16'd9002, 16'd9003, 16'd9000, 16'd9001};
      3'h4: tbl = {16'd9004, 16'd9006, 16'd0, 16'd0};
      3'h5: tbl = {16'd499, 16'd498, 16'd504, 16'd0};
      3'h6: tbl = {16'd9008, 16'd9009, 16'd9005, 16'd9007};
      default: tbl = 64'h0;
    endcase
    cyc_reg = tbl[63 - 16 * slot -: 16];
  endfunction

endpackage

// File: hw/cqr_handler.sv
/*
  CAN query responder and cyclic read generator of the power device.
  Assumes a CAN controller on sys_clk that offers received frames as one-cycle
  pulses and takes transmit frames by valid/ready, and a register store that
  answers a read strobe one cycle later with data or an error flag.
*/
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module cqr_handler #(
  parameter int MS_CYCLES = cqr_pkg::MS_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic rx_valid,
  input wire cqr_pkg::cqr_frame_type rx_frame,
  output logic tx_valid,
  output cqr_pkg::cqr_frame_type tx_frame,
  input wire logic tx_ready,
  input wire logic can_connected,
  output logic store_rd,
  output logic [15:0] store_addr,
  input wire logic [15:0] store_rdata,
  input wire logic store_err,
  input wire cqr_pkg::cqr_status_type dev_status
);

  typedef enum {ST_IDLE, ST_FETCH, ST_ISSUE, ST_TAKE, ST_SEND, ST_WAIT} cqr_state_type;

  cqr_state_type state_reg;
  logic [10:0] base_id_reg;
  logic [10:0] cyc_base_id_reg;
  logic cyc_en_reg;
  logic bidir_reg;
  logic [15:0] interval_reg [cqr_pkg::NUM_CYC];
  logic [15:0] count_reg [cqr_pkg::NUM_CYC];
  logic [cqr_pkg::NUM_CYC-1:0] due_reg;
  logic [31:0] bus_rdata_reg;
  logic [$clog2(MS_CYCLES)-1:0] div_reg;
  logic ms_tick_reg;
  logic qpend_reg;
  logic [15:0] qreg_reg;
  logic qbad_reg;
  logic job_query_reg;
  logic [2:0] job_obj_reg;
  logic [15:0] start_reg;
  logic [7:0] total_reg;
  logic [7:0] bidx_reg;
  logic [3:0] slot_reg;
  logic [7:0] marker_reg;
  logic split_reg;
  // Byte 0 of a frame is the top byte of its data field
  logic [0:7][7:0] buf_reg;
  logic [3:0] dlc_reg;
  logic tx_valid_reg;
  cqr_pkg::cqr_frame_type tx_frame_reg;
  logic store_rd_reg;
  logic [15:0] store_addr_reg;

  // Decode of the control port
  // Unmapped offsets read zero and drop writes
  wire logic [7:0] int_base = cqr_pkg::ADDR_INTERVAL0;
  wire logic [7:0] int_ofs = bus_addr - int_base;
  wire logic int_hit = (bus_addr >= int_base) && (int_ofs[7:2] < 6'(cqr_pkg::NUM_CYC)) && (bus_addr[1:0] == 2'b00);
  wire logic [2:0] int_idx = int_ofs[4:2];

  // Status word assembled from the device's loose flags
  wire logic [31:0] status_word;
  assign status_word[31:24] = {dev_status.remote, dev_status.output_on_req, dev_status.fast_regulator,
                               dev_status.voltage_current_power_regulation, dev_status.any_alarm,
                               dev_status.master_slave_safety_alarm, dev_status.overcurrent_event_alarm,
                               dev_status.overcurrent_protection_alarm};
  assign status_word[23:7] = {dev_status.access_interface, dev_status.power_event_alarm,
                              dev_status.power_protection_alarm, dev_status.overtemperature_alarm, 1'b0,
                              dev_status.voltage_event_alarm, dev_status.overvoltage_alarm, 1'b0,
                              dev_status.power_fail_alarm, 1'b0, dev_status.remote_standby,
                              dev_status.undercurrent_event, dev_status.undervoltage_event};
  assign status_word[6:0] = {dev_status.external_sensing, dev_status.function_generator,
                             dev_status.master_unit, dev_status.output_on, dev_status.regulation_mode,
                             dev_status.sink_side};

  // Incoming query decode
  // query identifier
  wire logic rx_is_query = rx_valid && (rx_frame.id == base_id_reg + cqr_pkg::QUERY_ID_OFS);
  wire logic [15:0] rx_reg = rx_frame.data[63:48];
  // Too short for a register field: answered with an error
  wire logic rx_short = rx_frame.dlc < cqr_pkg::DLC_QUERY_MIN;
  wire logic rx_take = rx_is_query && (rx_short || (rx_reg != cqr_pkg::ERR_REG));

  // Cyclic enable per object
  logic [cqr_pkg::NUM_CYC-1:0] obj_en;
  logic [2:0] due_pick;
  always_comb begin
    obj_en = '0;
    due_pick = 3'h0;
    for (int i = 0; i < cqr_pkg::NUM_CYC; i++) begin
      // zero interval disables; global enable and link
      obj_en[i] = cyc_en_reg && can_connected && (interval_reg[i] != 16'h0000)
                  && ((i < cqr_pkg::NUM_STD_CYC) || bidir_reg);
    end
    for (int i = cqr_pkg::NUM_CYC - 1; i >= 0; i--) begin
      if (due_reg[i]) begin
        due_pick = 3'(i);
      end
    end
  end

  function automatic logic [15:0] eff_interval(input logic [15:0] iv);
    eff_interval = (iv < cqr_pkg::MIN_INTERVAL_MS) ? cqr_pkg::MIN_INTERVAL_MS : iv;
  endfunction

  // Engine helper terms
  wire logic job_is_status = !job_query_reg && (job_obj_reg == cqr_pkg::STATUS_OBJ);
  // set values passed on in stored scale
  wire logic [15:0] word_now = job_is_status ? (bidx_reg[1] ? status_word[15:0] : status_word[31:16])
                                             : store_rdata;
  wire logic [7:0] byte_now = bidx_reg[0] ? word_now[7:0] : word_now[15:8];
  wire logic [7:0] bidx_inc = bidx_reg + 8'h01;
  // Slot seven holds the last byte of a frame
  wire logic frame_full = (slot_reg == 4'h7);
  wire logic last_byte = (bidx_inc == total_reg);
  wire logic [15:0] fetch_addr = job_query_reg ? (start_reg + {9'h000, bidx_reg[7:1]})
                                               : cqr_pkg::cyc_reg(job_obj_reg, bidx_reg[2:1]);
  wire logic [7:0] q_len = cqr_pkg::obj_len(qreg_reg);
  // single frame up to three registers; split beyond
  wire logic q_split = q_len > cqr_pkg::SINGLE_MAX_REGS;
  wire logic [10:0] resp_id = base_id_reg + cqr_pkg::RESP_ID_OFS;
  wire logic [10:0] cyc_id = cyc_base_id_reg + {8'h00, job_obj_reg};
  // Payload length of the next due cyclic object
  wire logic [7:0] due_words = cqr_pkg::cyc_words(due_pick);

  // Millisecond enable pulse
  // Free running, so the first tick after enabling comes within 1 ms
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (div_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1))) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
    ms_tick_reg <= !sys_rst && (div_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));
  end

  // Control port writes
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      base_id_reg <= cqr_pkg::BASE_ID_RESET;
      cyc_base_id_reg <= cqr_pkg::CYC_BASE_ID_RESET;
      cyc_en_reg <= 1'b0;
      bidir_reg <= 1'b0;
      for (int i = 0; i < cqr_pkg::NUM_CYC; i++) begin
        interval_reg[i] <= 16'h0000;
      end
    end else if (bus_wr) begin
      if (bus_addr == cqr_pkg::ADDR_BASE_ID) begin
        base_id_reg <= bus_wdata[10:0];
      end
      if (bus_addr == cqr_pkg::ADDR_CYC_BASE_ID) begin
        cyc_base_id_reg <= bus_wdata[10:0];
      end
      if (bus_addr == cqr_pkg::ADDR_CTRL) begin
        cyc_en_reg <= bus_wdata[cqr_pkg::CTRL_CYC_EN];
        bidir_reg <= bus_wdata[cqr_pkg::CTRL_BIDIR];
      end
      if (int_hit) begin
        interval_reg[int_idx] <= bus_wdata[15:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  // Busy and pending bits let software watch the engine
  always_ff @(posedge sys_clk) begin
    bus_rdata_reg <= 32'h0000_0000;
    if (!sys_rst && bus_rd) begin
      if (bus_addr == cqr_pkg::ADDR_BASE_ID) begin
        bus_rdata_reg <= {21'h000000, base_id_reg};
      end else if (bus_addr == cqr_pkg::ADDR_CYC_BASE_ID) begin
        bus_rdata_reg <= {21'h000000, cyc_base_id_reg};
      end else if (bus_addr == cqr_pkg::ADDR_CTRL) begin
        bus_rdata_reg <= {30'h00000000, bidir_reg, cyc_en_reg};
      end else if (bus_addr == cqr_pkg::ADDR_STATUS) begin
        bus_rdata_reg <= {17'h00000, due_reg, 6'h00, qpend_reg, (state_reg != ST_IDLE)};
      end else if (int_hit) begin
        bus_rdata_reg <= {16'h0000, interval_reg[int_idx]};
      end
    end
  end

  // Interval timers; a disabled object restarts at once when enabled
  // Trade-off: one shared tick limits timing to whole milliseconds
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < cqr_pkg::NUM_CYC; i++) begin
      if (sys_rst || !obj_en[i]) begin
        count_reg[i] <= 16'h0000;
      end else if (ms_tick_reg) begin
        if (count_reg[i] == 16'h0000) begin
          count_reg[i] <= eff_interval(interval_reg[i]) - 16'h0001;
        end else begin
          count_reg[i] <= count_reg[i] - 16'h0001;
        end
      end
    end
  end

  // Due flags; a new expiry wins over the engine taking the old one
  // Disabling an object drops its pending frame too
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < cqr_pkg::NUM_CYC; i++) begin
      if (sys_rst || !obj_en[i]) begin
        due_reg[i] <= 1'b0;
      end else if (ms_tick_reg && (count_reg[i] == 16'h0000)) begin
        due_reg[i] <= 1'b1;
      end else if ((state_reg == ST_IDLE) && !qpend_reg && (due_pick == 3'(i))) begin
        due_reg[i] <= 1'b0;
      end
    end
  end

  // One-deep query holder; a newer query replaces an unserved one
  // Limitation: a flood of queries is answered only for the latest
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      qpend_reg <= 1'b0;
      qreg_reg <= 16'h0000;
      qbad_reg <= 1'b0;
    end else if (rx_take) begin
      qpend_reg <= 1'b1;
      qreg_reg <= rx_reg;
      qbad_reg <= rx_short;
    end else if (state_reg == ST_IDLE) begin
      qpend_reg <= 1'b0;
    end
  end

  // Frame engine: queries first, then due cyclic objects
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      job_query_reg <= 1'b0;
      job_obj_reg <= 3'h0;
      start_reg <= 16'h0000;
      total_reg <= 8'h00;
      bidx_reg <= 8'h00;
      slot_reg <= 4'h0;
      marker_reg <= cqr_pkg::MARKER_FIRST;
      split_reg <= 1'b0;
      buf_reg <= '0;
      dlc_reg <= 4'h0;
      tx_valid_reg <= 1'b0;
      tx_frame_reg <= '0;
      store_rd_reg <= 1'b0;
      store_addr_reg <= 16'h0000;
    end else begin
      store_rd_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          bidx_reg <= 8'h00;
          buf_reg <= '0;
          marker_reg <= cqr_pkg::MARKER_FIRST;
          if (qpend_reg) begin
            job_query_reg <= 1'b1;
            start_reg <= qreg_reg;
            total_reg <= {q_len[6:0], 1'b0};
            split_reg <= q_split;
            buf_reg[0] <= qreg_reg[15:8];
            buf_reg[1] <= qreg_reg[7:0];
            if (qbad_reg) begin
              buf_reg[0] <= cqr_pkg::ERR_REG[15:8];
              buf_reg[1] <= cqr_pkg::ERR_REG[7:0];
              buf_reg[2] <= cqr_pkg::ERR_DATA;
              dlc_reg <= cqr_pkg::DLC_ERR;
              // Nothing follows the error frame
              total_reg <= 8'h00;
              state_reg <= ST_SEND;
            end else if (q_split) begin
              buf_reg[2] <= cqr_pkg::MARKER_FIRST;
              slot_reg <= cqr_pkg::SPLIT_HDR;
              state_reg <= ST_FETCH;
            end else begin
              slot_reg <= cqr_pkg::SINGLE_HDR;
              state_reg <= ST_FETCH;
            end
          end else if (|due_reg) begin
            job_query_reg <= 1'b0;
            job_obj_reg <= due_pick;
            total_reg <= {due_words[6:0], 1'b0};
            split_reg <= 1'b0;
            slot_reg <= 4'h0;
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          store_addr_reg <= fetch_addr;
          store_rd_reg <= !job_is_status;
          state_reg <= ST_ISSUE;
        end
        ST_ISSUE: begin
          // Store answers one cycle after the strobe
          state_reg <= ST_TAKE;
        end
        ST_TAKE: begin
          // A failed read aborts the rest of a query object; cyclic objects ignore store_err
          if (job_query_reg && store_err && !job_is_status) begin
            buf_reg <= '0;
            buf_reg[0] <= cqr_pkg::ERR_REG[15:8];
            buf_reg[1] <= cqr_pkg::ERR_REG[7:0];
            buf_reg[2] <= cqr_pkg::ERR_ADDR;
            dlc_reg <= cqr_pkg::DLC_ERR;
            bidx_reg <= total_reg;
            state_reg <= ST_SEND;
          end else begin
            buf_reg[slot_reg[2:0]] <= byte_now;
            bidx_reg <= bidx_inc;
            slot_reg <= slot_reg + 4'h1;
            dlc_reg <= split_reg ? cqr_pkg::DLC_FULL : (slot_reg + 4'h1);
            state_reg <= (frame_full || last_byte) ? ST_SEND : ST_FETCH;
          end
        end
        ST_SEND: begin
          // Frame stands unchanged until the controller takes it
          // response identifier; cyclic identifiers
          tx_frame_reg.id <= job_query_reg ? resp_id : cyc_id;
          tx_frame_reg.dlc <= dlc_reg;
          tx_frame_reg.data <= buf_reg;
          tx_valid_reg <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (tx_ready) begin
            tx_valid_reg <= 1'b0;
            if (bidx_reg == total_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              // Next split frame repeats the start register
              // marker counts down per frame
              buf_reg <= '0;
              buf_reg[0] <= start_reg[15:8];
              buf_reg[1] <= start_reg[7:0];
              buf_reg[2] <= marker_reg - 8'h01;
              marker_reg <= marker_reg - 8'h01;
              slot_reg <= cqr_pkg::SPLIT_HDR;
              state_reg <= ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  // No output is decoded, so none can glitch
  assign bus_rdata = bus_rdata_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_frame = tx_frame_reg;
  assign store_rd = store_rd_reg;
  assign store_addr = store_addr_reg;

endmodule

// File: testbench/cqr_monitor.sv
/*
  Port checker for the query and cyclic read handler.
  Assumes it is bound to cqr_handler and that IDs change only while idle.
*/
`timescale 1ns/1ps
module cqr_monitor #(
  parameter int MS_CYCLES = 25
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic rx_valid,
  input wire cqr_pkg::cqr_frame_type rx_frame,
  input wire logic tx_valid,
  input wire cqr_pkg::cqr_frame_type tx_frame,
  input wire logic tx_ready,
  input wire cqr_pkg::cqr_status_type dev_status
);
  logic [10:0] base_q;
  logic [10:0] cyc_q;
  int gap_q;
  // Decoded view of the offered frame
  wire acc = tx_valid && tx_ready;
  wire [10:0] ofs = tx_frame.id - cyc_q;
  wire is_cyc = ofs < 11'h007;
  wire is_q = tx_frame.id == base_q + cqr_pkg::RESP_ID_OFS;
  wire is_err = tx_frame.data[63:48] == cqr_pkg::ERR_REG;
  wire [3:0] cdlc = (ofs == 11'h000 || ofs == 11'h004) ? 4'h4 : (ofs == 11'h001 || ofs == 11'h005) ? 4'h6 : 4'h8;
  wire [31:0] sw = {dev_status[28:13], 1'b0, dev_status[12:11], 1'b0, dev_status[10], 1'b0, dev_status[9:0]};

  // Shadow IDs; gap counts cycles since the last status frame
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      base_q <= cqr_pkg::BASE_ID_RESET;
      cyc_q <= cqr_pkg::CYC_BASE_ID_RESET;
      gap_q <= 32'h7FFF_FFFF;
    end else begin
      if (bus_wr && bus_addr == cqr_pkg::ADDR_BASE_ID) base_q <= bus_wdata[10:0];
      if (bus_wr && bus_addr == cqr_pkg::ADDR_CYC_BASE_ID) cyc_q <= bus_wdata[10:0];
      if (acc && is_cyc && ofs == 11'h000) gap_q <= 1;
      else if (gap_q < 32'h7FFF_FFFF) gap_q <= gap_q + 1;
    end
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence offer_s;
    tx_valid && !tx_ready;
  endsequence
  sequence query_s;
    rx_valid && rx_frame.id == base_q + cqr_pkg::QUERY_ID_OFS && rx_frame.dlc >= 4'h2 && rx_frame.data[63:48] != 16'hFFFF;
  endsequence

  tx_hold_a: assert property (offer_s |=> tx_valid && $stable(tx_frame))
    else $error("offered frame dropped or changed");
  resp_id_a: assert property (tx_valid |-> is_q || is_cyc)
    else $error("frame on a foreign id");
  single_dlc_a: assert property (tx_valid && is_q && !is_err |-> tx_frame.dlc inside {4'h4, 4'h6, 4'h8})
    else $error("response length wrong");
  err_frame_a: assert property (tx_valid && is_q && is_err |-> tx_frame.dlc == 4'h3 && tx_frame.data[47:40] != 8'h00)
    else $error("error frame malformed");
  status_word_a: assert property (tx_valid && is_cyc && ofs == 11'h000 |-> tx_frame.data[63:32] == sw)
    else $error("status word wrong");
  cyc_dlc_a: assert property (tx_valid && is_cyc |-> tx_frame.dlc == cdlc)
    else $error("cyclic frame length wrong");
  status_gap_a: assert property (acc && is_cyc && ofs == 11'h000 |-> gap_q >= 19 * MS_CYCLES)
    else $error("status frames too close");
  query_answer_a: assert property (query_s |-> ##[1:400] tx_valid)
    else $error("query not answered");
endmodule

bind cqr_handler cqr_monitor #(.MS_CYCLES(MS_CYCLES)) u_cqr_monitor (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
  .dev_status(dev_status)
);

// File: testbench/cqr_host_model.sv
/*
  CAN host controller and device register store model.
  Assumes the handler's valid/ready transmit side and one-cycle store reads.
*/
`timescale 1ns/1ps
module cqr_host_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic [15:0] err_reg,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic store_rd,
  input wire logic [15:0] store_addr,
  output logic [15:0] store_rdata,
  output logic store_err
);
  logic [1:0] wait_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !tx_valid || tx_ready) begin
      wait_q <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      wait_q <= wait_q + 2'h1;
      tx_ready <= !slow || wait_q == 2'h3;
    end
  end
  always_ff @(posedge sys_clk) begin
    store_err <= !sys_rst && store_rd && store_addr == err_reg;
    if (sys_rst) store_rdata <= 16'h0000;
    else store_rdata <= store_rd ? store_addr ^ 16'hA5A5 : ~store_rdata;
  end
endmodule

// File: testbench/testbench.sv
/*
  Self-checking bench for the query and cyclic read handler.
  Assumes the host model on the far side and the bound monitor.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t: value %h", $time, a); end end
module testbench;
  logic sys_clk, sys_rst, bus_wr, bus_rd, rx_valid, tx_valid, tx_ready;
  logic can_connected, store_rd, store_err, slow;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [15:0] store_addr, store_rdata, err_reg, w;
  cqr_pkg::cqr_frame_type rx_frame, tx_frame, f;
  cqr_pkg::cqr_status_type dev_status;
  int bad_count, checked;
  time t0;
  logic [7:0] pay [40];
  wire [31:0] sw = {dev_status[28:13], 1'b0, dev_status[12:11], 1'b0, dev_status[10], 1'b0, dev_status[9:0]};

  cqr_handler #(.MS_CYCLES(25)) u_cqr_handler (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_ready(tx_ready), .can_connected(can_connected), .store_rd(store_rd),
    .store_addr(store_addr), .store_rdata(store_rdata), .store_err(store_err), .dev_status(dev_status)
  );
  cqr_host_model u_cqr_host_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow), .err_reg(err_reg), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .store_rd(store_rd), .store_addr(store_addr), .store_rdata(store_rdata),
    .store_err(store_err)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] sv(input logic [15:0] r);
    sv = r ^ 16'hA5A5;
  endfunction

  task automatic close_out;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 `CHK(bus_rdata, e)
  endtask

  task automatic query(input logic [10:0] id, input logic [3:0] dlc, input logic [15:0] r);
    @(posedge sys_clk);
    rx_frame <= '{id, dlc, {r, 48'h0}};
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
  endtask

  // Frame taken at the edge where valid and ready meet
  task automatic get;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        f = tx_frame;
        return;
      end
    end
    bad_count++;
    $display("unexpected %0t: no frame", $time);
    close_out();
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      `CHK(tx_valid, 1'b0)
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
    can_connected = 1'b0;
    slow = 1'b0;
    err_reg = 16'h0063;
    dev_status = 29'h1ACE_5A93;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h00, 32'h0000_0020);
    rd(8'h04, 32'h0000_0100);
    rd(8'h08, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0);
    wr(8'h00, 32'h0000_0088);
    rd(8'h00, 32'h0000_0088);
    $display("test registers done");
    query(11'h089, 4'h2, 16'h01F4);
    get();
    `CHK({f.id, f.dlc, f.data[63:32]}, {11'h08A, 4'h4, 16'h01F4, sv(16'h01F4)})
    query(11'h089, 4'h2, 16'h01F9);
    get();
    `CHK({f.dlc, f.data[47:16]}, {4'h6, sv(16'h01F9), sv(16'h01FA)})
    $display("test single done");
    slow <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      w = sv(16'h00AB + 16'(i / 2));
      pay[i] = i[0] ? w[7:0] : w[15:8];
    end
    query(11'h089, 4'h2, 16'h00AB);
    for (int k = 0; k < 8; k++) begin
      get();
      `CHK({f.dlc, f.data[63:40]}, {4'h8, 16'h00AB, 8'hFF - 8'(k)})
      `CHK(f.data[39:0], {pay[5*k], pay[5*k+1], pay[5*k+2], pay[5*k+3], pay[5*k+4]})
    end
    slow <= 1'b0;
    $display("test split done");
    query(11'h089, 4'h1, 16'h01F4);
    get();
    `CHK({f.dlc, f.data[63:40]}, {4'h3, 24'hFFFF03})
    query(11'h089, 4'h2, 16'h0063);
    get();
    `CHK({f.dlc, f.data[63:40]}, {4'h3, 24'hFFFF02})
    query(11'h089, 4'h2, 16'hFFFF);
    query(11'h088, 4'h2, 16'h01F4);
    quiet(300);
    $display("test errors done");
    wr(8'h10, 32'h1);
    wr(8'h14, 32'h14);
    wr(8'h24, 32'h14);
    wr(8'h08, 32'h1);
    quiet(100);
    can_connected <= 1'b1;
    get();
    t0 = $time;
    `CHK({f.id, f.dlc, f.data[63:32]}, {11'h100, 4'h4, sw})
    `CHK(f.data[32], dev_status.sink_side)
    get();
    `CHK({f.id, f.dlc, f.data[63:16]}, {11'h101, 4'h6, sv(16'h01FB), sv(16'h01FC), sv(16'h01FD)})
    `CHK(($time - t0) < 1600, 1'b1)
    get();
    `CHK(f.id, 11'h100)
    `CHK(($time - t0) inside {[19000:21000]}, 1'b1)
    get();
    wr(8'h08, 32'h0);
    quiet(600);
    $display("test cyclic done");
    close_out();
  end
endmodule
